/* File: rtl/sdc_device.sv */
// Summary of operation
// - Clock, select, data lines plus chain output
// - Control, address (7 bits), then data bytes
// - Every byte shifts most significant bit first
// - Host holds select across each byte
// - Gated clock: eight cycles per byte, idles high
// - Shared data wire needs host release on reads
// - Select falling mid-byte returns port to idle
// - Control byte fields: broadcast, read, space, channel
// - Output released during control and address bytes
// - Host keeps serial clock under the maximum
// - Nine event sources feed the pending flags
// - One pending flag, one mask bit each
// - Event sets its flag only when unmasked
// - Interrupt output low while any flag set
// - Reading a status register clears returned flags
// - Interrupt stays asserted while status is nonzero
// - Host reads status after seeing interrupt
// - Read bit one reads; space one selects registers
// - Channel field decrements per channel down chain
// - Broadcast keeps field, every channel writes
// - Host uses broadcast only for writes
`timescale 1ns/1ns
`default_nettype none
module sdc_device #(
  parameter int CHANNELS = 2,
  parameter int MEM_DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  sdc_link_if.device link,
  input wire logic [CHANNELS-1:0][sdc_pkg::NUM_EVENTS-1:0] event_req
);
  localparam int MIDX = $clog2(MEM_DEPTH);
  localparam logic [3:0] CH_SUB = 4'(CHANNELS);

  if (CHANNELS < 1 || CHANNELS > 15
      || MEM_DEPTH < 2 || MEM_DEPTH > 64) begin : g_bad_param
    $error("sdc_device: unsupported CHANNELS or MEM_DEPTH");
  end

  function automatic logic mem_ok(input logic [6:0] a);
    return int'(a) < MEM_DEPTH;
  endfunction : mem_ok

  logic [1:0] sclk_s, csn_s, sdi_s;
  logic sclk_d, csn_d, rise, fall, sel_fall, active, byte_done;
  sdc_pkg::sdc_dev_state_t state_r;
  logic [2:0] bit_r;
  logic [7:0] shift_r, shift_nxt, ctrl_r, wdata_r;
  logic [6:0] addr_r;
  logic two_r, bc_r, borrow_r, borrow_nxt, flip, sub_bit, chain_r;
  logic [3:0] channel_select_field;
  logic bc, rd, reg_sp, hit, capture, commit, drive, any_pend;
  logic [15:0] rd_val, tx_r;
  logic sdo_r, sdo_oe_r, int_n_r;
  logic [sdc_pkg::NUM_EVENTS-1:0] pend_r [CHANNELS];
  logic [sdc_pkg::NUM_EVENTS-1:0] mask_r [CHANNELS];
  logic [15:0] mem_r [CHANNELS][MEM_DEPTH];

  // Pin synchronisers; only the second stage is ever looked at
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_s <= 2'h3;
      csn_s <= 2'h3;
      sdi_s <= 2'h0;
      sclk_d <= 1'b1;
      csn_d <= 1'b1;
    end else if (clk_en) begin
      sclk_s <= {sclk_s[0], link.sclk};
      csn_s <= {csn_s[0], link.select_n};
      sdi_s <= {sdi_s[0], link.sdi};
      sclk_d <= sclk_s[1];
      csn_d <= csn_s[1];
    end
  end

  assign rise = sclk_s[1] & ~sclk_d;
  assign fall = ~sclk_s[1] & sclk_d;
  assign sel_fall = ~csn_s[1] & csn_d;
  assign active = ~csn_s[1];
  assign shift_nxt = {shift_r[6:0], sdi_s[1]};
  assign byte_done = rise & active & (bit_r == sdc_pkg::BIT_LAST);

  // Decoded control byte, valid from the address byte on
  assign channel_select_field = sdc_pkg::sdc_rev4(ctrl_r[sdc_pkg::CID_BITS-1:0]);
  assign bc = ctrl_r[sdc_pkg::BCAST_BIT];
  assign rd = ctrl_r[sdc_pkg::READ_BIT];
  assign reg_sp = ctrl_r[sdc_pkg::SPACE_BIT];
  assign hit = channel_select_field < CH_SUB;

  // Byte framing; state survives select going high between bytes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= sdc_pkg::SDC_ST_CTRL;
      bit_r <= sdc_pkg::BIT_FIRST;
      shift_r <= 8'h00;
      ctrl_r <= 8'h00;
      addr_r <= 7'h00;
      two_r <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall && bit_r != sdc_pkg::BIT_FIRST) begin
        state_r <= sdc_pkg::SDC_ST_CTRL;
        bit_r <= sdc_pkg::BIT_FIRST;
        two_r <= 1'b0;
      end else if (rise && active) begin
        bit_r <= bit_r + 3'h1;
        shift_r <= shift_nxt;
        if (bit_r == sdc_pkg::BIT_LAST) begin
          unique case (state_r)
            sdc_pkg::SDC_ST_CTRL: begin
              ctrl_r <= shift_nxt;
              state_r <= sdc_pkg::SDC_ST_ADDR;
            end
            sdc_pkg::SDC_ST_ADDR: begin
              addr_r <= shift_nxt[sdc_pkg::ADDR_BITS-1:0];
              two_r <= ~ctrl_r[sdc_pkg::SPACE_BIT];
              state_r <= sdc_pkg::SDC_ST_DATA;
            end
            sdc_pkg::SDC_ST_DATA: begin
              two_r <= 1'b0;
              if (!two_r) state_r <= sdc_pkg::SDC_ST_CTRL;
            end
          endcase
        end
      end
    end
  end

  // Serial subtract of the channel count on the channel bits
  always_comb begin
    sub_bit = CH_SUB[bit_r[1:0]];
    flip = 1'b0;
    if (state_r == sdc_pkg::SDC_ST_CTRL && bit_r[2] && !bc_r)
      flip = sub_bit ^ borrow_r;
    borrow_nxt = (~sdi_s[1] & (sub_bit | borrow_r)) | (sub_bit & borrow_r);
  end

  // Chain output follows the input with a few cycles of lag, which
  // bounds how many devices fit in one half period of the clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bc_r <= 1'b0;
      borrow_r <= 1'b0;
      chain_r <= 1'b0;
    end else if (clk_en) begin
      chain_r <= sdi_s[1] ^ flip;
      if (rise && active && state_r == sdc_pkg::SDC_ST_CTRL) begin
        if (bit_r == sdc_pkg::BIT_FIRST) begin
          bc_r <= sdi_s[1];
          borrow_r <= 1'b0;
        end else if (bit_r[2]) begin
          borrow_r <= borrow_nxt;
        end
      end
    end
  end

  // Read and write strobes for the addressed channel
  assign capture = byte_done && state_r == sdc_pkg::SDC_ST_ADDR
    && rd && hit && !bc;
  assign commit = byte_done && state_r == sdc_pkg::SDC_ST_DATA
    && !two_r && !rd;
  assign drive = active && state_r == sdc_pkg::SDC_ST_DATA
    && rd && hit && !bc;

  // Read value at the address just received
  always_comb begin
    rd_val = 16'h0000;
    for (int c = 0; c < CHANNELS; c++) begin
      if (channel_select_field == 4'(c)) begin
        if (reg_sp) begin
          unique case (shift_nxt[sdc_pkg::ADDR_BITS-1:0])
            sdc_pkg::ADDR_STATUS0: rd_val = {8'h00, pend_r[c][7:0]};
            sdc_pkg::ADDR_STATUS1: rd_val = {15'h0000, pend_r[c][8]};
            sdc_pkg::ADDR_MASK0: rd_val = {8'h00, mask_r[c][7:0]};
            sdc_pkg::ADDR_MASK1: rd_val = {15'h0000, mask_r[c][8]};
            default: rd_val = 16'h0000;
          endcase
        end else if (mem_ok(shift_nxt[6:0])) begin
          rd_val = mem_r[c][shift_nxt[MIDX-1:0]];
        end
      end
    end
  end

  // Output shifter: new bit on each falling edge of a read data byte, released otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_r <= 16'h0000;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end else if (clk_en) begin
      if (capture) tx_r <= reg_sp ? {rd_val[7:0], 8'h00} : rd_val;
      if (!drive) begin
        sdo_oe_r <= 1'b0;
      end else if (fall) begin
        sdo_oe_r <= 1'b1;
        sdo_r <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  // High byte of a memory write waits for the low byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdata_r <= 8'h00;
    end else if (clk_en) begin
      if (byte_done && state_r == sdc_pkg::SDC_ST_DATA && two_r)
        wdata_r <= shift_nxt;
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    logic mine, rd_me, wr_me, mem_done;
    logic [sdc_pkg::NUM_EVENTS-1:0] ev, clr;

    // Event gathering and read-to-clear of the flags returned
    always_comb begin
      mine = channel_select_field == 4'(c);
      rd_me = capture && mine;
      wr_me = commit && (bc || mine);
      mem_done = (rd_me || wr_me) && !reg_sp;
      ev = event_req[c];
      ev[sdc_pkg::EV_MEM_DONE] = ev[sdc_pkg::EV_MEM_DONE] | mem_done;
      clr = '0;
      if (rd_me && reg_sp) begin
        if (shift_nxt[6:0] == sdc_pkg::ADDR_STATUS0)
          clr[sdc_pkg::STATUS0_BITS-1:0] = pend_r[c][7:0];
        if (shift_nxt[6:0] == sdc_pkg::ADDR_STATUS1)
          clr[sdc_pkg::EV_MEM_DONE] = pend_r[c][8];
      end
    end

    // A new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) pend_r[c] <= sdc_pkg::PEND_RESET;
      else if (clk_en)
        pend_r[c] <= (pend_r[c] & ~clr) | (ev & mask_r[c]);
    end

    // Committed writes to mask register or memory
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        mask_r[c] <= sdc_pkg::MASK_RESET;
        for (int i = 0; i < MEM_DEPTH; i++) mem_r[c][i] <= 16'h0000;
      end else if (clk_en && wr_me) begin
        if (reg_sp) begin
          if (addr_r == sdc_pkg::ADDR_MASK0)
            mask_r[c][7:0] <= shift_nxt;
          if (addr_r == sdc_pkg::ADDR_MASK1) mask_r[c][8] <= shift_nxt[0];
        end else if (mem_ok(addr_r)) begin
          mem_r[c][addr_r[MIDX-1:0]] <= {wdata_r, shift_nxt};
        end
      end
    end
  end

  // Interrupt is the NOR of every pending flag
  always_comb begin
    any_pend = 1'b0;
    for (int c = 0; c < CHANNELS; c++) any_pend = any_pend | (|pend_r[c]);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) int_n_r <= 1'b1;
    else if (clk_en) int_n_r <= ~any_pend;
  end

  assign link.sdo = sdo_r;
  assign link.sdo_oe = sdo_oe_r;
  assign link.chain_serial_out = chain_r;
  assign link.int_n = int_n_r;
endmodule : sdc_device
`default_nettype wire

/* File: rtl/sdc_host.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_host #(
  parameter int SCLK_HALF = 10
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  sdc_link_if.host link,
  input wire logic req_valid,
  input wire logic req_read,
  input wire logic req_reg_space,
  input wire logic req_bcast,
  input wire logic [3:0] req_cid,
  input wire logic [6:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  output logic irq
);
  localparam int CW = $clog2(SCLK_HALF + 1);
  localparam logic [CW-1:0] HALF_M1 = CW'(SCLK_HALF - 1);

  if (SCLK_HALF < sdc_pkg::SCLK_MIN_HALF
      || SCLK_HALF < sdc_pkg::HOST_MIN_HALF) begin : g_bad_half
    $error("sdc_host: SCLK_HALF too small");
  end

  sdc_pkg::sdc_host_state_t st_r;
  logic [CW-1:0] cnt_r;
  logic [5:0] left_r, data_r;
  logic [31:0] tx_r, frame;
  logic [15:0] rx_r;
  logic [7:0] ctrl;
  logic [1:0] sdo_s, int_s;
  logic rd_r, rs_r, sclk_r, csn_r, sdi_r, oe_r, ready_r, rv_r, irq_r;
  logic [15:0] rdata_r;
  logic tick, in_data;

  // Frame image, sent most significant bit first
  always_comb begin
    ctrl = {req_bcast, req_read, req_reg_space, 1'b0,
      sdc_pkg::sdc_rev4(req_cid)};
    if (req_reg_space) frame = {ctrl, 1'b0, req_addr, req_wdata[7:0], 8'h00};
    else frame = {ctrl, 1'b0, req_addr, req_wdata};
  end

  assign tick = cnt_r == '0;
  assign in_data = rd_r && left_r <= data_r;

  // Pin synchronisers for returning lines
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_s <= 2'h0;
      int_s <= 2'h3;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      sdo_s <= {sdo_s[0], link.sdo_line};
      int_s <= {int_s[0], link.int_n};
      irq_r <= ~int_s[1];
    end
  end

  // Whole transaction under one select; clock idles high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= sdc_pkg::SDC_H_IDLE;
      cnt_r <= '0;
      left_r <= 6'h00;
      data_r <= 6'h00;
      tx_r <= 32'h0000_0000;
      rx_r <= 16'h0000;
      rd_r <= 1'b0;
      rs_r <= 1'b0;
      sclk_r <= 1'b1;
      csn_r <= 1'b1;
      sdi_r <= 1'b0;
      oe_r <= 1'b0;
      ready_r <= 1'b1;
      rv_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else if (clk_en) begin
      rv_r <= 1'b0;
      if (!tick) cnt_r <= cnt_r - 1'b1;
      unique case (st_r)
        sdc_pkg::SDC_H_IDLE: begin
          if (req_valid) begin
            tx_r <= frame;
            rd_r <= req_read & ~req_bcast;
            rs_r <= req_reg_space;
            left_r <= req_reg_space ? sdc_pkg::FRAME_REG_BITS
              : sdc_pkg::FRAME_MEM_BITS;
            data_r <= req_reg_space ? sdc_pkg::DATA_REG_BITS
              : sdc_pkg::DATA_MEM_BITS;
            csn_r <= 1'b0;
            oe_r <= 1'b1;
            ready_r <= 1'b0;
            cnt_r <= HALF_M1;
            st_r <= sdc_pkg::SDC_H_LEAD;
          end
        end
        sdc_pkg::SDC_H_LEAD: begin
          if (tick) st_r <= sdc_pkg::SDC_H_SHIFT;
        end
        sdc_pkg::SDC_H_SHIFT: begin
          if (tick) begin
            cnt_r <= HALF_M1;
            if (sclk_r) begin
              sclk_r <= 1'b0;
              sdi_r <= tx_r[31];
              tx_r <= {tx_r[30:0], 1'b0};
              oe_r <= ~in_data;
            end else begin
              sclk_r <= 1'b1;
              left_r <= left_r - 6'h01;
              if (in_data) rx_r <= {rx_r[14:0], sdo_s[1]};
              if (left_r == 6'h01) st_r <= sdc_pkg::SDC_H_TRAIL;
            end
          end
        end
        sdc_pkg::SDC_H_TRAIL: begin
          if (tick) begin
            csn_r <= 1'b1;
            oe_r <= 1'b0;
            ready_r <= 1'b1;
            rv_r <= rd_r;
            rdata_r <= rs_r ? {8'h00, rx_r[7:0]} : rx_r;
            st_r <= sdc_pkg::SDC_H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.select_n = csn_r;
  assign link.sdi = sdi_r;
  assign link.sdi_oe = oe_r;
  assign req_ready = ready_r;
  assign resp_valid = rv_r;
  assign resp_rdata = rdata_r;
  assign irq = irq_r;
endmodule : sdc_host
`default_nettype wire

/* File: rtl/sdc_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface sdc_link_if;
  logic sclk;
  logic select_n;
  logic sdi;
  logic sdi_oe;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;
  logic chain_serial_out;
  logic int_n;

  // Released output line is pulled low
  assign sdo_line = sdo_oe ? sdo : 1'b0;

  modport device(input sclk, input select_n, input sdi, output sdo,
    output sdo_oe, output chain_serial_out, output int_n);
  modport host(output sclk, output select_n, output sdi, output sdi_oe,
    input sdo_line, input int_n);
endinterface : sdc_link_if
`default_nettype wire

/* File: rtl/sdc_pkg.sv */
package sdc_pkg;
  // Control byte layout
  localparam int BCAST_BIT = 7;
  localparam int READ_BIT = 6;
  localparam int SPACE_BIT = 5;
  localparam int CID_BITS = 4;
  localparam int ADDR_BITS = 7;
  localparam int BYTE_BITS = 8;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Event sources, one pending flag and one mask bit each
  localparam int NUM_EVENTS = 9;
  localparam int EV_LOOP = 0;
  localparam int EV_GND_KEY = 1;
  localparam int EV_RING_TRIP = 2;
  localparam int EV_POWER_ALARM = 3;
  localparam int EV_RING_ACTIVE = 4;
  localparam int EV_RING_INACTIVE = 5;
  localparam int EV_PM_ACTIVE = 6;
  localparam int EV_PM_INACTIVE = 7;
  localparam int EV_MEM_DONE = 8;
  localparam int STATUS0_BITS = 8;
  // Register space map
  localparam logic [6:0] ADDR_STATUS0 = 7'h00;
  localparam logic [6:0] ADDR_STATUS1 = 7'h01;
  localparam logic [6:0] ADDR_MASK0 = 7'h02;
  localparam logic [6:0] ADDR_MASK1 = 7'h03;
  localparam logic [8:0] PEND_RESET = 9'h000;
  localparam logic [8:0] MASK_RESET = 9'h000;
  // Frame lengths seen by the host
  localparam logic [5:0] FRAME_REG_BITS = 6'h18;
  localparam logic [5:0] FRAME_MEM_BITS = 6'h20;
  localparam logic [5:0] DATA_REG_BITS = 6'h08;
  localparam logic [5:0] DATA_MEM_BITS = 6'h10;
  // Serial clock limit against the system clock
  localparam real CLK_MHZ = 125.0;
  localparam real SCLK_MAX_MHZ = 16.13;
  localparam int SCLK_MIN_HALF = int'($ceil(CLK_MHZ / SCLK_MAX_MHZ / 2.0));
  // Device needs sync plus edge detect before its output settles
  localparam int HOST_MIN_HALF = 8;

  typedef enum logic [2:0] {
    SDC_ST_CTRL = 3'b001,
    SDC_ST_ADDR = 3'b010,
    SDC_ST_DATA = 3'b100
  } sdc_dev_state_t;

  typedef enum logic [3:0] {
    SDC_H_IDLE = 4'b0001,
    SDC_H_LEAD = 4'b0010,
    SDC_H_SHIFT = 4'b0100,
    SDC_H_TRAIL = 4'b1000
  } sdc_host_state_t;

  // Channel field travels least significant bit first
  function automatic logic [3:0] sdc_rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction : sdc_rev4
endpackage : sdc_pkg

/* File: tb/sdc_link_props.sv */
`timescale 1ns/1ns
`default_nettype none
module sdc_link_props #(
  parameter int CHANNELS = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic sdi,
  input wire logic sdi_oe,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line,
  input wire logic chain_serial_out,
  input wire logic int_n
);
  logic sclk_q_r;
  logic [5:0] cnt_r;
  logic [7:0] ctrl_r;
  logic [6:0] addr_r;
  logic stat_rd_r;
  logic [7:0] half_r;
  logic rise_w;
  logic [3:0] cid_w;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Channel field arrives least significant bit first
  assign rise_w = sclk && !sclk_q_r && !select_n;
  assign cid_w = {ctrl_r[0], ctrl_r[1], ctrl_r[2], ctrl_r[3]};

  // Serial clock edge finder
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sclk_q_r <= 1'b1;
    else sclk_q_r <= sclk;
  end

  // Bit count kept after select rises, so late releases still see it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cnt_r <= 6'h00;
    else if ($fell(select_n)) cnt_r <= 6'h00;
    else if (rise_w) cnt_r <= cnt_r + 6'h01;
  end

  // Header capture for control and address bytes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= 8'h00;
      addr_r <= 7'h00;
    end else if (rise_w && cnt_r < 6'h08) begin
      ctrl_r <= {ctrl_r[6:0], sdi};
    end else if (rise_w && cnt_r < 6'h10) begin
      addr_r <= {addr_r[5:0], sdi};
    end
  end

  // Notes a status read that some channel answers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) stat_rd_r <= 1'b0;
    else if ($fell(select_n)) stat_rd_r <= 1'b0;
    else if (rise_w && cnt_r == 6'h0f && ctrl_r[6] && ctrl_r[5] &&
             !ctrl_r[7] && addr_r[5:0] == 6'h00 && cid_w < CHANNELS)
      stat_rd_r <= 1'b1;
  end

  // Cycles since the serial clock last moved
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) half_r <= 8'hff;
    else if ($changed(sclk)) half_r <= 8'h01;
    else if (half_r != 8'hff) half_r <= half_r + 8'h01;
  end

  a_hdr_released: assert property (sdo_oe |-> cnt_r >= 6'h10)
    else $error("data output driven during header");
  a_rd_only_drive: assert property (sdo_oe |->
    ctrl_r[6] && !ctrl_r[7] && cid_w < CHANNELS)
    else $error("data output driven outside an addressed read");
  a_shared_free: assert property (sdo_oe |-> !sdi_oe)
    else $error("both ends drive the data wire");
  a_idle_high: assert property (select_n |-> sclk)
    else $error("serial clock low outside a frame");
  a_clk_in_frame: assert property ($changed(sclk) |-> !select_n)
    else $error("serial clock moved while deselected");
  a_whole_frame: assert property ($rose(select_n) |-> cnt_r ==
    (ctrl_r[5] ? sdc_pkg::FRAME_REG_BITS : sdc_pkg::FRAME_MEM_BITS))
    else $error("frame length wrong for its space");
  a_sclk_rate: assert property ($changed(sclk) |->
    half_r >= sdc_pkg::SCLK_MIN_HALF)
    else $error("serial clock half period too short");
  a_sdi_steady: assert property (rise_w && sdi_oe |-> $stable(sdi))
    else $error("input data moved at sampling edge");
  a_int_clear_rd: assert property ($rose(int_n) |-> stat_rd_r)
    else $error("interrupt released without status read");
endmodule : sdc_link_props
`default_nettype wire

/* File: tb/spi_daisy_chain_control_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_daisy_chain_control_port_tb_top;
  localparam int HALF = 8;
  logic clk;
  logic reset_n;
  logic req_valid;
  logic req_read;
  logic req_reg_space;
  logic req_bcast;
  logic [3:0] req_cid;
  logic [6:0] req_addr;
  logic [15:0] req_wdata;
  logic req_ready;
  logic resp_valid;
  logic [15:0] resp_rdata;
  logic irq;
  logic [1:0][sdc_pkg::NUM_EVENTS-1:0] ev_r;
  logic [15:0] exp_q[$];
  logic [7:0] m;
  logic [7:0] rx;
  logic [15:0] w;
  integer seed;
  int mismatches;
  int samples_checked;
  logic en;
  logic [7:0] ch_q[$];
  logic [7:0] ch_sh;
  logic [3:0] ch_n;
  logic sclk_q;

  sdc_link_if sdc_link_if_inst ();
  sdc_link_if raw_if ();

  sdc_device sdc_device_inst (.clk(clk), .reset_n(reset_n), .clk_en(en),
    .link(sdc_link_if_inst.device), .event_req(ev_r));
  sdc_host #(.SCLK_HALF(HALF)) sdc_host_inst (.clk(clk), .reset_n(reset_n),
    .clk_en(en), .link(sdc_link_if_inst.host), .req_valid(req_valid),
    .req_read(req_read), .req_reg_space(req_reg_space),
    .req_bcast(req_bcast), .req_cid(req_cid), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .irq(irq));
  // Second device is driven bit by bit to break framing on purpose
  sdc_device sdc_device_raw_inst (.clk(clk), .reset_n(reset_n),
    .clk_en(en), .link(raw_if.device), .event_req(18'h00000));
  sdc_link_props #(.CHANNELS(2)) sdc_link_props_inst (.clk(clk),
    .reset_n(reset_n), .sclk(sdc_link_if_inst.sclk),
    .select_n(sdc_link_if_inst.select_n), .sdi(sdc_link_if_inst.sdi),
    .sdi_oe(sdc_link_if_inst.sdi_oe), .sdo(sdc_link_if_inst.sdo),
    .sdo_oe(sdc_link_if_inst.sdo_oe), .sdo_line(sdc_link_if_inst.sdo_line),
    .chain_serial_out(sdc_link_if_inst.chain_serial_out),
    .int_n(sdc_link_if_inst.int_n));

  // Free running system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    mismatches += exp_q.size() + ch_q.size();
    $display("mismatches %0d samples_checked %0d", mismatches,
      samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // One host request; a read leaves its expected word in the queue
  task automatic req(input logic rd, input logic rs, input logic bc,
    input logic [3:0] channel_select_field, input logic [6:0] a, input logic [15:0] wd,
    input logic [15:0] ex);
    int k;
    logic [3:0] c;
    k = 0;
    c = bc ? channel_select_field : channel_select_field - 4'h2;
    if (rd && !bc) exp_q.push_back(ex);
    // Two channels per device, so the forwarded field drops by two
    ch_q.push_back({bc, rd, rs, 1'b0, c[0], c[1], c[2], c[3]});
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    req_valid <= 1'b1;
    req_read <= rd;
    req_reg_space <= rs;
    req_bcast <= bc;
    req_cid <= channel_select_field;
    req_addr <= a;
    req_wdata <= wd;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (2) @(negedge clk);
    while (req_ready !== 1'b1 && k < 8000) begin
      @(negedge clk);
      k++;
    end
  endtask : req

  // Gated clock byte, 40 ns low then 40 ns high, sampled at the rise
  task automatic xfer(input logic [7:0] tx, input int n,
    output logic [7:0] r);
    r = tx;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clk);
      raw_if.sclk <= 1'b0;
      raw_if.sdi <= tx[i];
      repeat (5) @(posedge clk);
      raw_if.sclk <= 1'b1;
      r[i] = raw_if.sdo_line;
      repeat (4) @(posedge clk);
    end
  endtask : xfer

  task automatic raw_frame(input logic [7:0] c, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    raw_if.select_n <= 1'b0;
    repeat (4) @(posedge clk);
    xfer(c, 8, r);
    xfer(a, 8, r);
    xfer(d, 8, r);
    repeat (5) @(posedge clk);
    raw_if.select_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : raw_frame

  // Each read result is matched against the oldest note
  always @(posedge clk) begin
    if (resp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(resp_rdata, 16'hxxxx);
      else chk(resp_rdata, exp_q.pop_front());
    end
  end

  // Forwarded control byte, taken where a next device would sample it
  always @(posedge clk) begin
    sclk_q <= sdc_link_if_inst.sclk;
    if (sdc_link_if_inst.select_n !== 1'b0) begin
      ch_n <= 4'h0;
    end else if (sdc_link_if_inst.sclk && !sclk_q && ch_n < 4'h8) begin
      ch_sh = {ch_sh[6:0], sdc_link_if_inst.chain_serial_out};
      ch_n <= ch_n + 4'h1;
      if (ch_n == 4'h7) begin
        if (ch_q.size() == 0) chk({8'h00, ch_sh}, 16'hxxxx);
        else chk({8'h00, ch_sh}, {8'h00, ch_q.pop_front()});
      end
    end
  end

  // Hang guard, well past the expected run of some 11,500 cycles
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    {req_valid, req_read, req_reg_space, req_bcast} = 4'h0;
    req_cid = 4'h0;
    req_addr = 7'h00;
    req_wdata = 16'h0000;
    ev_r = '0;
    raw_if.sclk = 1'b1;
    raw_if.select_n = 1'b1;
    raw_if.sdi = 1'b0;
    raw_if.sdi_oe = 1'b0;
    seed = 58950;
    en = 1'b1;
    mismatches = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    req(1, 1, 0, 4'h0, sdc_pkg::ADDR_MASK0, 16'h0000, 16'h0000);
    req(1, 1, 0, 4'h0, sdc_pkg::ADDR_STATUS0, 16'h0000, 16'h0000);
    m = 8'($random(seed));
    m[0] = 1'b1;
    req(0, 1, 0, 4'h0, sdc_pkg::ADDR_MASK0, {8'h00, m}, 16'h0);
    req(0, 1, 0, 4'h0, sdc_pkg::ADDR_MASK1, 16'h0001, 16'h0);
    // Every source fires once on both channels; channel 1 is masked
    @(posedge clk);
    ev_r <= '1;
    @(posedge clk);
    ev_r <= '0;
    repeat (8) @(negedge clk);
    chk({15'h0000, irq}, 16'h0001);
    req(1, 1, 0, 4'h0, sdc_pkg::ADDR_STATUS0, 16'h0, {8'h00, m});
    repeat (8) @(negedge clk);
    chk({15'h0000, irq}, 16'h0001);
    req(1, 1, 0, 4'h0, sdc_pkg::ADDR_STATUS1, 16'h0, 16'h0001);
    req(1, 1, 0, 4'h0, sdc_pkg::ADDR_STATUS0, 16'h0, 16'h0000);
    req(1, 1, 0, 4'h1, sdc_pkg::ADDR_STATUS0, 16'h0, 16'h0000);
    repeat (8) @(negedge clk);
    chk({15'h0000, irq}, 16'h0000);
    // Memory word only on channel 1; nobody answers channel 2
    w = 16'($random(seed));
    req(0, 0, 0, 4'h1, 7'h03, w, 16'h0000);
    // Both ends frozen for a while in mid-frame; the read must survive
    fork
      req(1, 0, 0, 4'h1, 7'h03, 16'h0000, w);
      begin
        repeat (200) @(posedge clk);
        en <= 1'b0;
        repeat (24) @(posedge clk);
        en <= 1'b1;
      end
    join
    req(1, 0, 0, 4'h0, 7'h03, 16'h0000, 16'h0000);
    req(1, 0, 0, 4'h2, 7'h03, 16'h0000, 16'h0000);
    req(0, 1, 1, 4'h5, sdc_pkg::ADDR_MASK0, 16'h00a5, 16'h0);
    req(1, 1, 0, 4'h0, sdc_pkg::ADDR_MASK0, 16'h0, 16'h00a5);
    req(1, 1, 0, 4'h1, sdc_pkg::ADDR_MASK0, 16'h0, 16'h00a5);
    // Back-to-back random words, ends of the store included
    for (int i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      req(0, 0, 0, 4'h0, 7'(i * 5), w, 16'h0000);
      req(1, 0, 0, 4'h0, 7'(i * 5), 16'h0000, w);
    end
    // Three stray bits, then a clean write and read back on the raw link
    @(posedge clk);
    raw_if.select_n <= 1'b0;
    repeat (4) @(posedge clk);
    xfer(8'hff, 3, rx);
    @(posedge clk);
    raw_if.select_n <= 1'b1;
    repeat (8) @(posedge clk);
    raw_frame(8'h20, 8'h02, 8'h3c, rx);
    raw_frame(8'h60, 8'h02, 8'h00, rx);
    chk({8'h00, rx}, 16'h003c);
    stop_test();
  end
endmodule : spi_daisy_chain_control_port_tb_top
`default_nettype wire
